/* File: rtl/ddif_cfg_if.sv */
`timescale 1ns/1ps
interface ddif_cfg_if;
	import ddif_pkg::*;
	logic [DDIF_CNT_W-1:0] limit;
	logic                  raw;
	logic                  level;
	modport ctrl (output limit, output raw, input level);
	modport filt (input limit, input raw, output level);
endinterface : ddif_cfg_if

/* File: rtl/ddif_filter.sv */
`timescale 1ns/1ps
module ddif_filter
	import ddif_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	ddif_cfg_if.filt  cfg
);
	logic                  level_reg;
	logic                  level_next;
	logic [DDIF_CNT_W-1:0] cnt_reg;
	logic [DDIF_CNT_W-1:0] cnt_next;

	// Symmetric stable-time debounce; counter restarts on any bounce
	always_comb begin
		level_next = level_reg;
		cnt_next   = '0;
		if (cfg.raw != level_reg) begin
			if (cnt_reg >= cfg.limit - 1'b1) begin
				level_next = cfg.raw;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_reg <= 1'b0;
			cnt_reg   <= '0;
		end else begin
			level_reg <= level_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign cfg.level = level_reg;
endmodule : ddif_filter

/* File: rtl/ddif_pkg.sv */
package ddif_pkg;
	localparam int unsigned DDIF_CHANNELS = 8;
	localparam int unsigned DDIF_CLK_HZ   = 40000000;
	// Input delay figures in microseconds
	localparam int unsigned DDIF_DLY0_US  = 500;
	localparam int unsigned DDIF_DLY1_US  = 3000;
	localparam int unsigned DDIF_DLY2_US  = 15000;
	localparam int unsigned DDIF_DLY3_US  = 20000;
	localparam int unsigned DDIF_DLY0_CYC = DDIF_DLY0_US * (DDIF_CLK_HZ / 1000000);
	localparam int unsigned DDIF_DLY1_CYC = DDIF_DLY1_US * (DDIF_CLK_HZ / 1000000);
	localparam int unsigned DDIF_DLY2_CYC = DDIF_DLY2_US * (DDIF_CLK_HZ / 1000000);
	localparam int unsigned DDIF_DLY3_CYC = DDIF_DLY3_US * (DDIF_CLK_HZ / 1000000);
	localparam int unsigned DDIF_CNT_W    = 20;
	localparam logic [1:0]  DDIF_DLY_RST  = 2'h1;
	// Register byte addresses
	localparam logic [7:0] DDIF_A_CTRL    = 8'h00;
	localparam logic [7:0] DDIF_A_SC_EN   = 8'h04;
	localparam logic [7:0] DDIF_A_WB_EN   = 8'h08;
	localparam logic [7:0] DDIF_A_RISE_EN = 8'h0C;
	localparam logic [7:0] DDIF_A_FALL_EN = 8'h10;
	localparam logic [7:0] DDIF_A_LEVEL   = 8'h14;
	localparam logic [7:0] DDIF_A_SC_ST   = 8'h18;
	localparam logic [7:0] DDIF_A_WB_ST   = 8'h1C;
	localparam logic [7:0] DDIF_A_RISE_ST = 8'h20;
	localparam logic [7:0] DDIF_A_FALL_ST = 8'h24;
	localparam logic [7:0] DDIF_A_GROUP   = 8'h28;
	// Control field positions
	localparam int unsigned DDIF_CTRL_DLY_LO = 0;
	localparam int unsigned DDIF_CTRL_DIAG   = 2;
	localparam int unsigned DDIF_CTRL_HW     = 3;
	localparam logic [7:0]  DDIF_RST_BYTE    = 8'h00;
endpackage : ddif_pkg

/* File: rtl/ddif_top.sv */
`timescale 1ns/1ps
// Operation
// - Four module delays, 3 ms after reset
// - Same delay for both transition directions
// - Eight independent filtered input channels
// - Short-circuit report only when channel enabled
// - Wire-break report only when channel enabled
// - Diagnostic interrupt gated by diagnostic enable
// - Rising and falling edges separate sources
// - Rising interrupt needs channel enable
// - Falling interrupt needs channel enable
// - Module hardware enable gates edge enables
module ddif_top
	import ddif_pkg::*;
#(
	parameter int unsigned DLY0_CYC = DDIF_DLY0_CYC,
	parameter int unsigned DLY1_CYC = DDIF_DLY1_CYC,
	parameter int unsigned DLY2_CYC = DDIF_DLY2_CYC,
	parameter int unsigned DLY3_CYC = DDIF_DLY3_CYC
) (
	input  wire logic                       clock_i,
	input  wire logic                       rst_b_i,
	input  wire logic [ddif_pkg::DDIF_CHANNELS-1:0] in_pin_i,
	input  wire logic [ddif_pkg::DDIF_CHANNELS-1:0] short_det_i,
	input  wire logic [ddif_pkg::DDIF_CHANNELS-1:0] break_det_i,
	input  wire logic [7:0]                 addr_i,
	input  wire logic [31:0]                wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [31:0]                rdata_o,
	output logic      [ddif_pkg::DDIF_CHANNELS-1:0] level_o,
	output logic      [ddif_pkg::DDIF_CHANNELS-1:0] chan_fault_o,
	output logic                            group_fault_indicator_o,
	output logic                            diag_irq_o,
	output logic                            hw_irq_o
);
	import ddif_pkg::*;
	localparam int unsigned N = DDIF_CHANNELS;

	function automatic logic [N-1:0] w1c(input logic [N-1:0] st, input logic [N-1:0] set,
		input logic clr_en, input logic [N-1:0] clr);
		// Set wins over a same-cycle clear
		w1c = (clr_en ? (st & ~clr) : st) | set;
	endfunction : w1c

	function automatic logic [2:0] sync_step(input logic [2:0] s, input logic d);
		sync_step = {s[1:0], d};
	endfunction : sync_step

	function automatic logic any_set(input logic [N-1:0] v);
		any_set = |v;
	endfunction : any_set

	function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] target);
		wr_hit = we && (a == target);
	endfunction : wr_hit

	// Input synchronisers: stage0 feeds stage1 only; stages 1 and 2 must agree
	logic [2:0] in_s_reg [N];
	logic [2:0] in_s_next[N];
	logic [2:0] sc_s_reg [N];
	logic [2:0] sc_s_next[N];
	logic [2:0] wb_s_reg [N];
	logic [2:0] wb_s_next[N];
	logic [N-1:0] in_q_reg;
	logic [N-1:0] in_q_next;
	logic [N-1:0] sc_q_reg;
	logic [N-1:0] sc_q_next;
	logic [N-1:0] wb_q_reg;
	logic [N-1:0] wb_q_next;

	always_comb begin
		in_q_next = in_q_reg;
		sc_q_next = sc_q_reg;
		wb_q_next = wb_q_reg;
		for (int i = 0; i < N; i++) begin
			in_s_next[i] = sync_step(in_s_reg[i], in_pin_i[i]);
			sc_s_next[i] = sync_step(sc_s_reg[i], short_det_i[i]);
			wb_s_next[i] = sync_step(wb_s_reg[i], break_det_i[i]);
			if (in_s_reg[i][1] == in_s_reg[i][2]) begin
				in_q_next[i] = in_s_reg[i][2];
			end
			if (sc_s_reg[i][1] == sc_s_reg[i][2]) begin
				sc_q_next[i] = sc_s_reg[i][2];
			end
			if (wb_s_reg[i][1] == wb_s_reg[i][2]) begin
				wb_q_next[i] = wb_s_reg[i][2];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < N; i++) begin
				in_s_reg[i] <= 3'h0;
				sc_s_reg[i] <= 3'h0;
				wb_s_reg[i] <= 3'h0;
			end
			in_q_reg <= '0;
			sc_q_reg <= '0;
			wb_q_reg <= '0;
		end else begin
			in_s_reg <= in_s_next;
			sc_s_reg <= sc_s_next;
			wb_s_reg <= wb_s_next;
			in_q_reg <= in_q_next;
			sc_q_reg <= sc_q_next;
			wb_q_reg <= wb_q_next;
		end
	end

	// Configuration registers
	logic [1:0]   dly_reg;
	logic [1:0]   dly_next;
	logic         diag_en_reg;
	logic         diag_en_next;
	logic         hw_en_reg;
	logic         hw_en_next;
	logic [N-1:0] sc_en_reg;
	logic [N-1:0] sc_en_next;
	logic [N-1:0] wb_en_reg;
	logic [N-1:0] wb_en_next;
	logic [N-1:0] rise_en_reg;
	logic [N-1:0] rise_en_next;
	logic [N-1:0] fall_en_reg;
	logic [N-1:0] fall_en_next;
	logic         wr_ctrl;
	logic         wr_sc_en;
	logic         wr_wb_en;
	logic         wr_rise_en;
	logic         wr_fall_en;
	logic         wr_sc_st;
	logic         wr_wb_st;
	logic         wr_rise_st;
	logic         wr_fall_st;

	// One decoded write strobe per writable register (none for LEVEL or GROUP)
	assign wr_ctrl    = wr_hit(wr_i, addr_i, DDIF_A_CTRL);
	assign wr_sc_en   = wr_hit(wr_i, addr_i, DDIF_A_SC_EN);
	assign wr_wb_en   = wr_hit(wr_i, addr_i, DDIF_A_WB_EN);
	assign wr_rise_en = wr_hit(wr_i, addr_i, DDIF_A_RISE_EN);
	assign wr_fall_en = wr_hit(wr_i, addr_i, DDIF_A_FALL_EN);
	assign wr_sc_st   = wr_hit(wr_i, addr_i, DDIF_A_SC_ST);
	assign wr_wb_st   = wr_hit(wr_i, addr_i, DDIF_A_WB_ST);
	assign wr_rise_st = wr_hit(wr_i, addr_i, DDIF_A_RISE_ST);
	assign wr_fall_st = wr_hit(wr_i, addr_i, DDIF_A_FALL_ST);

	always_comb begin
		dly_next     = dly_reg;
		diag_en_next = diag_en_reg;
		hw_en_next   = hw_en_reg;
		sc_en_next   = sc_en_reg;
		wb_en_next   = wb_en_reg;
		rise_en_next = rise_en_reg;
		fall_en_next = fall_en_reg;
		if (wr_ctrl) begin
			dly_next     = wdata_i[DDIF_CTRL_DLY_LO +: 2];
			diag_en_next = wdata_i[DDIF_CTRL_DIAG];
			hw_en_next   = wdata_i[DDIF_CTRL_HW];
		end
		if (wr_sc_en) begin
			sc_en_next = wdata_i[N-1:0];
		end
		if (wr_wb_en) begin
			wb_en_next = wdata_i[N-1:0];
		end
		// edge enables writable only with module enable
		if (wr_rise_en && hw_en_reg) begin
			rise_en_next = wdata_i[N-1:0];
		end
		if (wr_fall_en && hw_en_reg) begin
			fall_en_next = wdata_i[N-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dly_reg     <= DDIF_DLY_RST;
			diag_en_reg <= 1'b0;
			hw_en_reg   <= 1'b0;
			sc_en_reg   <= DDIF_RST_BYTE;
			wb_en_reg   <= DDIF_RST_BYTE;
			rise_en_reg <= DDIF_RST_BYTE;
			fall_en_reg <= DDIF_RST_BYTE;
		end else begin
			dly_reg     <= dly_next;
			diag_en_reg <= diag_en_next;
			hw_en_reg   <= hw_en_next;
			sc_en_reg   <= sc_en_next;
			wb_en_reg   <= wb_en_next;
			rise_en_reg <= rise_en_next;
			fall_en_reg <= fall_en_next;
		end
	end

	logic [DDIF_CNT_W-1:0] limit;
	always_comb begin
		case (dly_reg)
			2'h0:    limit = DDIF_CNT_W'(DLY0_CYC);
			2'h1:    limit = DDIF_CNT_W'(DLY1_CYC);
			2'h2:    limit = DDIF_CNT_W'(DLY2_CYC);
			default: limit = DDIF_CNT_W'(DLY3_CYC);
		endcase
	end

	logic [N-1:0] level;
	for (genvar g = 0; g < N; g++) begin : g_chan
		ddif_cfg_if cfg_if ();
		assign cfg_if.limit = limit;
		assign cfg_if.raw   = in_q_reg[g];
		assign level[g]     = cfg_if.level;
		ddif_filter u_filt (
			.clock_i (clock_i),
			.rst_b_i (rst_b_i),
			.cfg     (cfg_if.filt)
		);
	end

	// Edge detection and sticky status
	logic [N-1:0] lvl_d_reg;
	logic [N-1:0] rise_st_reg;
	logic [N-1:0] rise_st_next;
	logic [N-1:0] fall_st_reg;
	logic [N-1:0] fall_st_next;
	logic [N-1:0] sc_st_reg;
	logic [N-1:0] sc_st_next;
	logic [N-1:0] wb_st_reg;
	logic [N-1:0] wb_st_next;
	logic [N-1:0] rise_ev;
	logic [N-1:0] fall_ev;
	logic [N-1:0] edge_gate;

	assign rise_ev   = level & ~lvl_d_reg;
	assign fall_ev   = ~level & lvl_d_reg;
	assign edge_gate = {N{hw_en_reg}};

	always_comb begin
		rise_st_next = w1c(rise_st_reg, rise_ev & rise_en_reg & edge_gate,
			wr_rise_st, wdata_i[N-1:0]);
		fall_st_next = w1c(fall_st_reg, fall_ev & fall_en_reg & edge_gate,
			wr_fall_st, wdata_i[N-1:0]);
		sc_st_next   = w1c(sc_st_reg, sc_q_reg & sc_en_reg,
			wr_sc_st, wdata_i[N-1:0]);
		wb_st_next   = w1c(wb_st_reg, wb_q_reg & wb_en_reg,
			wr_wb_st, wdata_i[N-1:0]);
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lvl_d_reg   <= '0;
			rise_st_reg <= '0;
			fall_st_reg <= '0;
			sc_st_reg   <= '0;
			wb_st_reg   <= '0;
		end else begin
			lvl_d_reg   <= level;
			rise_st_reg <= rise_st_next;
			fall_st_reg <= fall_st_next;
			sc_st_reg   <= sc_st_next;
			wb_st_reg   <= wb_st_next;
		end
	end

	// Read port, data one cycle after strobe; unmapped reads zero
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	always_comb begin
		rdata_next = 32'h0;
		if (rd_i) begin
			case (addr_i)
				DDIF_A_CTRL:    rdata_next = {28'h0, hw_en_reg, diag_en_reg, dly_reg};
				DDIF_A_SC_EN:   rdata_next = {24'h0, sc_en_reg};
				DDIF_A_WB_EN:   rdata_next = {24'h0, wb_en_reg};
				DDIF_A_RISE_EN: rdata_next = {24'h0, rise_en_reg};
				DDIF_A_FALL_EN: rdata_next = {24'h0, fall_en_reg};
				DDIF_A_LEVEL:   rdata_next = {24'h0, level};
				DDIF_A_SC_ST:   rdata_next = {24'h0, sc_st_reg};
				DDIF_A_WB_ST:   rdata_next = {24'h0, wb_st_reg};
				DDIF_A_RISE_ST: rdata_next = {24'h0, rise_st_reg};
				DDIF_A_FALL_ST: rdata_next = {24'h0, fall_st_reg};
				DDIF_A_GROUP:   rdata_next = {31'h0, group_fault_indicator_o};
				default:        rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_reg <= 32'h0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs taken from next values, so registering adds no latency
	logic [N-1:0] fault_reg;
	logic [N-1:0] fault_next;
	logic         group_reg;
	logic         group_next;
	logic         diag_irq_reg;
	logic         diag_irq_next;
	logic         hw_irq_reg;
	logic         hw_irq_next;

	always_comb begin
		fault_next    = sc_st_next | wb_st_next;
		// group flag is OR of faults
		group_next    = any_set(fault_next);
		diag_irq_next = diag_en_next && any_set(fault_next);
		// Edge status already gated at set time, so level output stays simple
		hw_irq_next   = hw_en_next && any_set(rise_st_next | fall_st_next);
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fault_reg    <= '0;
			group_reg    <= 1'b0;
			diag_irq_reg <= 1'b0;
			hw_irq_reg   <= 1'b0;
		end else begin
			fault_reg    <= fault_next;
			group_reg    <= group_next;
			diag_irq_reg <= diag_irq_next;
			hw_irq_reg   <= hw_irq_next;
		end
	end

	assign rdata_o      = rdata_reg;
	assign level_o      = level;
	assign chan_fault_o = fault_reg;
	assign group_fault_indicator_o = group_reg;
	assign diag_irq_o   = diag_irq_reg;
	assign hw_irq_o     = hw_irq_reg;
endmodule : ddif_top

/* File: verif/ddif_chk.sv */
`timescale 1ns/1ps
module ddif_chk
	import ddif_pkg::*;
#(
	parameter int unsigned DLY0_CYC = DDIF_DLY0_CYC,
	parameter int unsigned DLY1_CYC = DDIF_DLY1_CYC,
	parameter int unsigned DLY2_CYC = DDIF_DLY2_CYC,
	parameter int unsigned DLY3_CYC = DDIF_DLY3_CYC
) (
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic [7:0]  in_pin_i,
	input wire logic [7:0]  short_det_i,
	input wire logic [7:0]  break_det_i,
	input wire logic [7:0]  addr_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [7:0]  level_o,
	input wire logic [7:0]  chan_fault_o,
	input wire logic        group_fault_indicator_o,
	input wire logic        diag_irq_o,
	input wire logic        hw_irq_o
);
	logic [7:0] det;
	assign det = short_det_i | break_det_i;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	a_rdata_idle: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0) else $error("read data outside answer cycle");
	a_group_or: assert property (
		group_fault_indicator_o == |chan_fault_o) else $error("group flag differs from channel faults");
	a_diag_cause: assert property (
		diag_irq_o |-> |chan_fault_o) else $error("diagnostic interrupt without fault");
	a_hw_rise_cause: assert property (
		$rose(hw_irq_o) |-> $past(level_o) != $past(level_o, 2) || $past(wr_i)) else $error("edge interrupt without edge");
	a_level_settled: assert property (
		((level_o ^ $past(level_o)) & (level_o ^ $past(in_pin_i, 5))) == 8'h00) else $error("level flip early");
	a_fault_cause: assert property (
		(chan_fault_o & ~$past(chan_fault_o) & ~($past(det, 2) | $past(det, 3) | $past(det, 4)
		| $past(det, 5) | $past(det, 6))) == 8'h00) else $error("fault without detector");
	a_hw_hold: assert property (
		$fell(hw_irq_o) |-> $past(wr_i)) else $error("edge interrupt dropped without write");
	a_diag_hold: assert property (
		$fell(diag_irq_o) |-> $past(wr_i)) else $error("diagnostic interrupt dropped without write");
	cover property ($rose(hw_irq_o));
	cover property ($rose(diag_irq_o));
	cover property (rd_i && addr_i == 8'h3C);
endmodule : ddif_chk
bind ddif_top ddif_chk #(.DLY0_CYC(DLY0_CYC), .DLY1_CYC(DLY1_CYC), .DLY2_CYC(DLY2_CYC), .DLY3_CYC(DLY3_CYC)) chk (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .in_pin_i(in_pin_i), .short_det_i(short_det_i),
	.break_det_i(break_det_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.level_o(level_o), .chan_fault_o(chan_fault_o), .group_fault_indicator_o(group_fault_indicator_o),
	.diag_irq_o(diag_irq_o), .hw_irq_o(hw_irq_o));

/* File: verif/ddif_host.sv */
`timescale 1ns/1ps
module ddif_host
	import ddif_pkg::*;
(
	input  wire logic        clock_i,
	output logic      [7:0]  addr_o,
	output logic      [31:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	logic [31:0] exp_q[$];
	logic        hw_en = 1'b0;
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit rogue = 0);
		// edge enables only with module enable, unless rogue
		if (!rogue && !hw_en && (a == DDIF_A_RISE_EN || a == DDIF_A_FALL_EN))
			return;
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		if (a == DDIF_A_CTRL)
			hw_en = d[DDIF_CTRL_HW];
		@(posedge clock_i);
		wr_o <= 1'b0;
		// Released bus shows junk, not old values
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
	endtask : rd
endmodule : ddif_host

/* File: verif/test_diag_digital_input_filter.sv */
`timescale 1ns/1ps
module test_diag_digital_input_filter;
	import ddif_pkg::*;
	logic        clock_i = 0, rst_b_i = 0, wr_i, rd_i, rd_seen = 0;
	logic [7:0]  in_pin_i = 0, short_det_i = 0, break_det_i = 0, addr_i, pat, en, level_o, chan_fault_o;
	logic [31:0] wdata_i, rdata_o;
	logic        group_fault_indicator_o, diag_irq_o, hw_irq_o;
	int          num_errors = 0, total_checks = 0, n, n1;
	always #12.5 clock_i = ~clock_i;
	ddif_top #(.DLY0_CYC(4), .DLY1_CYC(8), .DLY2_CYC(16), .DLY3_CYC(32)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.in_pin_i(in_pin_i), .short_det_i(short_det_i), .break_det_i(break_det_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .level_o(level_o),
		.chan_fault_o(chan_fault_o), .group_fault_indicator_o(group_fault_indicator_o),
		.diag_irq_o(diag_irq_o), .hw_irq_o(hw_irq_o));
	ddif_host host (.clock_i(clock_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Bounded wait, then settle one more cycle
	task automatic wait_til(input logic [7:0] exp);
		n = 0;
		while (level_o !== exp && n < 200) begin
			@(negedge clock_i);
			n++;
		end
		@(negedge clock_i);
		chk(n < 200, 1);
	endtask : wait_til
	always @(posedge clock_i) rd_seen <= rd_i;
	always @(negedge clock_i) begin
		if (rd_seen) begin
			if (host.exp_q.size() == 0)
				chk(1, 0);
			else
				chk(rdata_o, host.exp_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		give_verdict();
	end
	initial begin
		n = $urandom(32'hc1dd5754);
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1;
		host.rd(DDIF_A_CTRL, 32'h1);
		host.rd(DDIF_A_SC_EN, 0);
		host.rd(DDIF_A_RISE_EN, 0);
		host.wr(DDIF_A_RISE_EN, 32'hFF, 1);
		host.rd(DDIF_A_RISE_EN, 0);
		host.rd(8'h3C, 0);
		for (int s = 0; s < 4; s++) begin
			host.wr(DDIF_A_CTRL, s);
			for (int v = 1; v >= 0; v--) begin
				@(posedge clock_i);
				in_pin_i[0] <= v[0];
				n = 0;
				while (level_o[0] !== v[0] && n < 100) begin
					@(negedge clock_i);
					n++;
				end
				chk(n >= (4 << s) + 2 && n <= (4 << s) + 7, 1);
				if (v)
					n1 = n;
				else
					chk(n, n1);
			end
		end
		pat = $urandom | 8'h01;
		host.wr(DDIF_A_CTRL, 32'h8);
		host.wr(DDIF_A_RISE_EN, 32'hFF);
		host.wr(DDIF_A_FALL_EN, 32'h0F);
		@(posedge clock_i) in_pin_i <= pat;
		wait_til(pat);
		chk(level_o, pat);
		chk(hw_irq_o, 1);
		host.rd(DDIF_A_RISE_ST, pat);
		host.rd(DDIF_A_FALL_ST, 0);
		host.wr(DDIF_A_RISE_ST, 32'hFF);
		@(negedge clock_i) chk(hw_irq_o, 0);
		@(posedge clock_i) in_pin_i <= 0;
		wait_til(0);
		host.rd(DDIF_A_FALL_ST, pat & 8'h0F);
		host.wr(DDIF_A_FALL_ST, 32'hFF);
		en = ($urandom & 8'h7F) | 8'h01;
		host.wr(DDIF_A_SC_EN, en);
		@(posedge clock_i) short_det_i <= 8'hFF;
		repeat (8) @(negedge clock_i);
		chk(chan_fault_o, en);
		chk(group_fault_indicator_o, 1);
		chk(diag_irq_o, 0);
		host.wr(DDIF_A_CTRL, 32'h4);
		@(negedge clock_i) chk(diag_irq_o, 1);
		host.wr(DDIF_A_WB_EN, ~en);
		@(posedge clock_i) short_det_i <= 0;
		break_det_i <= 8'hFF;
		repeat (8) @(posedge clock_i);
		host.wr(DDIF_A_SC_ST, 32'hFF);
		host.rd(DDIF_A_SC_ST, 0);
		host.rd(DDIF_A_WB_ST, {24'h0, ~en});
		@(posedge clock_i) break_det_i <= 0;
		repeat (8) @(posedge clock_i);
		host.wr(DDIF_A_WB_ST, 32'hFF);
		@(negedge clock_i) chk(group_fault_indicator_o, 0);
		chk(diag_irq_o, 0);
		// Module enable is off, so these edges must stay unlatched
		@(posedge clock_i) in_pin_i <= pat;
		wait_til(pat);
		chk(hw_irq_o, 0);
		host.rd(DDIF_A_RISE_ST, 0);
		repeat (2) @(negedge clock_i);
		give_verdict();
	end
endmodule : test_diag_digital_input_filter
